/* hw/rtc_cfg_defs.svh */
`ifndef RTC_CFG_DEFS_SVH
`define RTC_CFG_DEFS_SVH

// Word byte addresses on the register bus.
`define OFS_CFG 4'h0
`define OFS_PAD 4'h4
`define OFS_VAL 4'h8
`define OFS_KEY 4'hC

// Configuration and pad register bit positions.
`define BIT_EN 15
`define BIT_WREN 13
`define BIT_SYNC 12
`define BIT_HALF 11
`define BIT_OE 10
`define BIT_PTR_HI 9
`define BIT_PTR_LO 8
`define BIT_SECSEL 1
`define BIT_TTL 0

// Reset values.
`define CFG_RESET 16'h0000
`define PAD_RESET 2'h0

// Unlock key bytes.
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// Timekeeping counts in timekeeping clock pulses and half seconds.
`define HALF_TICKS 16'sh4000
`define SYNC_WINDOW 16'sh0020
`define HALVES_PER_MIN 7'h77
`define TRIM_STEP 16'sh0004

`endif

/* hw/rtc_cfg_pkg.sv */
package rtc_cfg_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;

  typedef struct packed {
    logic calendar_module_enable;
    logic value_write_enable;
    logic rollover_sync_flag;
    logic half_second_status;
    logic calendar_output_enable;
    logic [1:0] value_window_pointer;
    logic [7:0] trim;
  } cfg_t;

  typedef struct packed {
    cfg_t cfg;
    logic seconds_tick_select;
    logic parallel_port_ttl_select;
    key_state_t key;
    logic signed [15:0] ticks;
    logic [6:0] halves;
    logic [3:0][15:0] vals;
    logic ack;
    logic [31:0] dat;
    logic pin;
  } state_t;

endpackage : rtc_cfg_pkg

/* hw/rtc_config_write_lock.sv */
// What this block does
// [RULE1] Writes to the value window are dropped unless the value write enable bit 13 is set.
// [RULE2] Bit 13 can be set only by the access right after the 55h then AAh key writes.
// [RULE3] Software should keep bit 13 cleared whenever it is not updating the time.
// [RULE4] Bit 15 enables the calendar module and is writable only while bit 13 is 1.
// [RULE5] Read-only bit 11 is 1 in the second half of each second and 0 in the first half.
// [RULE6] A write to the low byte of the minutes and seconds value clears bit 11.
// [RULE7] Bit 10 drives the calendar output pin when 1 and holds it off when 0.
// [RULE8] The pointer in bits 9-8 counts down on each high window byte access and stops at 00.
// [RULE9] Pointer 00 selects minutes and seconds, 01 weekday and hours, 10 month and day, 11 year.
// [RULE10] The configuration register resets to zero on power-on reset only.
// [RULE11] Positive trim adds 4 timekeeping pulses per minute per step, up to 508.
// [RULE12] Negative trim subtracts 4 pulses per minute per step, down to 512.
// [RULE13] A read of either window byte also counts the pointer down.
// [RULE14] Pad bit 1 picks the seconds clock or the alarm pulse for the pin, gated by bit 10.
// [RULE15] Read-only bit 12 is set while a rollover ripple may disturb window reads.
// [RULE16] Bit 14 and pad bits 15-2 read as zero.
`timescale 1ns/1ps
`include "rtc_cfg_defs.svh"

module rtc_config_write_lock
  import rtc_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic TICK_IN,
  input wire logic ALARM_PULSE,
  output logic CAL_OUT
);

  state_t r;
  state_t next_r;

  logic take;
  logic wr;
  logic rd;
  logic [3:0] adr;
  assign take = WB_CYC_I && WB_STB_I && !r.ack;
  assign wr = take && WB_WE_I;
  assign rd = take && !WB_WE_I;
  assign adr = {WB_ADR_I[3:2], 2'b00};

  always_comb begin
    logic [15:0] cfg_word;
    logic [15:0] win;
    logic win_hi_wr;
    logic win_lo_wr;
    logic half_event;
    logic minute_end;
    cfg_word = 16'h0000;
    win = 16'h0000;
    win_hi_wr = 1'b0;
    win_lo_wr = 1'b0;
    half_event = 1'b0;
    minute_end = 1'b0;
    next_r = r;
    next_r.ack = take;
    next_r.dat = 32'h0000_0000;

    // Timekeeping phase runs only while the module is enabled.
    if (r.cfg.calendar_module_enable && TICK_IN) begin
      half_event = r.ticks >= (`HALF_TICKS - `TRIM_STEP / `TRIM_STEP);
      if (half_event) begin
        next_r.cfg.half_second_status = !r.cfg.half_second_status; // RULE5
        minute_end = r.cfg.half_second_status && (r.halves == `HALVES_PER_MIN);
        next_r.halves = minute_end ? 7'h00 : r.halves + 7'h01;
        // The trim preloads the pulse counter once per minute, so a positive step
        // shortens the minute by four pulses and a negative one lengthens it.
        next_r.ticks = minute_end ? 16'(`TRIM_STEP * $signed(r.cfg.trim)) : 16'sh0000; // RULE11 RULE12
      end else begin
        next_r.ticks = r.ticks + 16'sh0001;
      end
    end
    next_r.cfg.rollover_sync_flag = r.cfg.calendar_module_enable && r.cfg.half_second_status
      && (r.ticks >= `HALF_TICKS - `SYNC_WINDOW); // RULE15

    // Pointer 11 has no high byte, so it reads as zero.
    win = r.vals[r.cfg.value_window_pointer]; // RULE9
    if (r.cfg.value_window_pointer == 2'b11) begin
      win[15:8] = 8'h00;
    end

    // Any bus access closes the unlock window; only a key write reopens a stage.
    if (take) begin
      next_r.key = KEY_IDLE;
      if (wr && adr == `OFS_KEY && WB_SEL_I[0]) begin
        if (WB_DAT_I[7:0] == `KEY_FIRST) begin
          next_r.key = KEY_GOT_FIRST;
        end else if (WB_DAT_I[7:0] == `KEY_SECOND && r.key == KEY_GOT_FIRST) begin
          next_r.key = KEY_ARMED;
        end
      end
    end

    case (adr)
      `OFS_CFG: begin
        cfg_word = {r.cfg.calendar_module_enable, 1'b0, r.cfg.value_write_enable,
          r.cfg.rollover_sync_flag, r.cfg.half_second_status, r.cfg.calendar_output_enable,
          r.cfg.value_window_pointer, r.cfg.trim}; // RULE16
        if (rd) begin
          next_r.dat = {16'h0000, cfg_word};
        end
        if (wr && WB_SEL_I[1]) begin
          if (r.cfg.value_write_enable) begin
            next_r.cfg.calendar_module_enable = WB_DAT_I[`BIT_EN]; // RULE4
          end
          if (!WB_DAT_I[`BIT_WREN]) begin
            next_r.cfg.value_write_enable = 1'b0;
          end else if (r.key == KEY_ARMED) begin
            next_r.cfg.value_write_enable = 1'b1; // RULE2
          end
          next_r.cfg.calendar_output_enable = WB_DAT_I[`BIT_OE];
          next_r.cfg.value_window_pointer = WB_DAT_I[`BIT_PTR_HI:`BIT_PTR_LO];
        end
        if (wr && WB_SEL_I[0]) begin
          next_r.cfg.trim = WB_DAT_I[7:0];
        end
      end
      `OFS_PAD: begin
        if (rd) begin
          next_r.dat = {30'h0000_0000, r.seconds_tick_select, r.parallel_port_ttl_select}; // RULE16
        end
        if (wr && WB_SEL_I[0]) begin
          next_r.seconds_tick_select = WB_DAT_I[`BIT_SECSEL];
          next_r.parallel_port_ttl_select = WB_DAT_I[`BIT_TTL];
        end
      end
      `OFS_VAL: begin
        win_hi_wr = wr && WB_SEL_I[1];
        win_lo_wr = wr && WB_SEL_I[0];
        if (rd) begin
          next_r.dat = {16'h0000, win};
        end
        if (r.cfg.value_write_enable) begin // RULE1
          if (win_hi_wr && r.cfg.value_window_pointer != 2'b11) begin
            next_r.vals[r.cfg.value_window_pointer][15:8] = WB_DAT_I[15:8];
          end
          if (win_lo_wr) begin
            next_r.vals[r.cfg.value_window_pointer][7:0] = WB_DAT_I[7:0];
            if (r.cfg.value_window_pointer == 2'b00) begin
              next_r.cfg.half_second_status = 1'b0; // RULE6
              next_r.ticks = 16'sh0000;
            end
          end
        end
        // The core cannot tell a byte read from a word read, so every read counts.
        if ((rd || win_hi_wr) && r.cfg.value_window_pointer != 2'b00) begin
          next_r.cfg.value_window_pointer = r.cfg.value_window_pointer - 2'b01; // RULE8 RULE13
        end
      end
      default: begin
      end
    endcase

    next_r.pin = r.cfg.calendar_output_enable // RULE7
      && (r.seconds_tick_select ? r.cfg.half_second_status : ALARM_PULSE); // RULE14
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0; // RULE10
    end else begin
      r <= next_r;
    end
  end

  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.dat;
  assign CAL_OUT = r.pin;

  AST_LOCKED_WRITE: assert property (@(posedge CLK) disable iff (SRST) // RULE1
    (wr && adr == `OFS_VAL && !r.cfg.value_write_enable) |=> $stable(r.vals))
    else $error("Value window changed while writes were locked.");

  AST_UNLOCK_NEEDS_KEY: assert property (@(posedge CLK) disable iff (SRST) // RULE2
    $rose(r.cfg.value_write_enable) |-> $past(r.key) == KEY_ARMED)
    else $error("Write enable was set without the key sequence.");

  AST_ENABLE_GUARD: assert property (@(posedge CLK) disable iff (SRST) // RULE4
    (wr && adr == `OFS_CFG && !r.cfg.value_write_enable) |=> $stable(r.cfg.calendar_module_enable))
    else $error("Module enable changed while locked.");

  AST_HALF_CLEAR: assert property (@(posedge CLK) disable iff (SRST) // RULE6
    (wr && adr == `OFS_VAL && WB_SEL_I[0] && r.cfg.value_write_enable
      && r.cfg.value_window_pointer == 2'b00) |=> !r.cfg.half_second_status)
    else $error("Half second status not cleared by seconds write.");

  AST_PIN_GATED: assert property (@(posedge CLK) disable iff (SRST) // RULE7
    !r.cfg.calendar_output_enable ##1 !$past(SRST) |-> !CAL_OUT)
    else $error("Output pin active while output enable is clear.");

  AST_PTR_DOWN: assert property (@(posedge CLK) disable iff (SRST) // RULE8
    (rd && adr == `OFS_VAL && r.cfg.value_window_pointer != 2'b00)
      |=> r.cfg.value_window_pointer == $past(r.cfg.value_window_pointer) - 2'b01)
    else $error("Pointer did not count down on window read.");

  AST_PTR_FLOOR: assert property (@(posedge CLK) disable iff (SRST) // RULE8
    (r.cfg.value_window_pointer == 2'b00 && !(wr && adr == `OFS_CFG))
      |=> r.cfg.value_window_pointer == 2'b00)
    else $error("Pointer left 00 without a reload.");

  AST_POR_CLEAR: assert property (@(posedge CLK) // RULE10
    SRST |=> (r.cfg == '0 && !CAL_OUT && !WB_ACK_O))
    else $error("Configuration not cleared by power-on reset.");

  AST_TRIM_LOAD: assert property (@(posedge CLK) disable iff (SRST) // RULE11
    (r.cfg.calendar_module_enable && TICK_IN && r.cfg.half_second_status
      && r.halves == `HALVES_PER_MIN && r.ticks >= `HALF_TICKS - 16'sh0001
      && !(wr && adr inside {`OFS_VAL, `OFS_CFG}))
      |=> r.ticks == 16'(`TRIM_STEP * $signed($past(r.cfg.trim))))
    else $error("Trim not applied at the minute boundary.");

  AST_ACK_ONE: assert property (@(posedge CLK) disable iff (SRST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("Acknowledge held for more than one cycle.");

  AST_ACK_FOLLOWS: assert property (@(posedge CLK) disable iff (SRST)
    take |=> WB_ACK_O)
    else $error("Accepted access was not acknowledged in the next cycle.");

  // The key checks guard the only path to the write enable, so a stray stage must never linger.
  AST_KEY_ARM: assert property (@(posedge CLK) disable iff (SRST) // RULE2
    (wr && adr == `OFS_KEY && WB_SEL_I[0] && WB_DAT_I[7:0] == `KEY_SECOND
      && r.key == KEY_GOT_FIRST) |=> r.key == KEY_ARMED)
    else $error("Second key byte did not arm the unlock.");

  AST_KEY_CLOSE: assert property (@(posedge CLK) disable iff (SRST) // RULE2
    (take && !(wr && adr == `OFS_KEY)) |=> r.key == KEY_IDLE)
    else $error("Unlock stage survived an unrelated access.");

  AST_WREN_CLEAR: assert property (@(posedge CLK) disable iff (SRST) // RULE1
    (wr && adr == `OFS_CFG && WB_SEL_I[1] && !WB_DAT_I[`BIT_WREN])
      |=> !r.cfg.value_write_enable)
    else $error("Write enable not cleared by a zero write.");

  AST_RUN_GATE: assert property (@(posedge CLK) disable iff (SRST) // RULE4
    (!r.cfg.calendar_module_enable && !(wr && adr == `OFS_VAL)) |=> $stable(r.ticks))
    else $error("Timekeeping advanced while the module was disabled.");

  AST_HALF_RO: assert property (@(posedge CLK) disable iff (SRST) // RULE5
    (!(r.cfg.calendar_module_enable && TICK_IN) && !(wr && adr == `OFS_VAL))
      |=> $stable(r.cfg.half_second_status))
    else $error("Half second status changed without a tick or a seconds write.");

  AST_HALF_TOGGLE: assert property (@(posedge CLK) disable iff (SRST) // RULE5
    (r.cfg.calendar_module_enable && TICK_IN && r.ticks >= `HALF_TICKS - 16'sh0001
      && !(wr && adr == `OFS_VAL))
      |=> r.cfg.half_second_status != $past(r.cfg.half_second_status))
    else $error("Half second status did not toggle at the half boundary.");

  AST_OE_WRITE: assert property (@(posedge CLK) disable iff (SRST) // RULE7
    (wr && adr == `OFS_CFG && WB_SEL_I[1])
      |=> r.cfg.calendar_output_enable == $past(WB_DAT_I[`BIT_OE]))
    else $error("Output enable did not take the written value.");

  AST_PTR_WRITE_DOWN: assert property (@(posedge CLK) disable iff (SRST) // RULE8
    (wr && adr == `OFS_VAL && WB_SEL_I[1] && r.cfg.value_window_pointer != 2'b00)
      |=> r.cfg.value_window_pointer == $past(r.cfg.value_window_pointer) - 2'b01)
    else $error("Pointer did not count down on high byte write.");

  AST_WIN_READ: assert property (@(posedge CLK) disable iff (SRST) // RULE9
    $past(rd && adr == `OFS_VAL && r.cfg.value_window_pointer == 2'b00)
      |-> WB_DAT_O[15:0] == $past(r.vals[0]))
    else $error("Pointer 00 did not return minutes and seconds.");

  AST_TRIM_WRITE: assert property (@(posedge CLK) disable iff (SRST) // RULE11
    (wr && adr == `OFS_CFG && WB_SEL_I[0]) |=> r.cfg.trim == $past(WB_DAT_I[7:0]))
    else $error("Trim did not take the written value.");

  AST_PIN_FOLLOW: assert property (@(posedge CLK) disable iff (SRST) // RULE14
    1'b1 |=> CAL_OUT == $past(r.cfg.calendar_output_enable
      && (r.seconds_tick_select ? r.cfg.half_second_status : ALARM_PULSE)))
    else $error("Output pin does not follow the selected source.");

  AST_PAD_WRITE: assert property (@(posedge CLK) disable iff (SRST) // RULE14
    (wr && adr == `OFS_PAD && WB_SEL_I[0])
      |=> r.seconds_tick_select == $past(WB_DAT_I[`BIT_SECSEL]))
    else $error("Seconds select did not take the written value.");

  AST_SYNC_IDLE: assert property (@(posedge CLK) disable iff (SRST) // RULE15
    !r.cfg.calendar_module_enable |=> !r.cfg.rollover_sync_flag)
    else $error("Sync flag set while the module was disabled.");

  // Software polls this flag before reading the window, so a late flag means torn reads.
  AST_SYNC_WINDOW: assert property (@(posedge CLK) disable iff (SRST) // RULE15
    (r.cfg.calendar_module_enable && r.cfg.half_second_status
      && r.ticks >= `HALF_TICKS - `SYNC_WINDOW) |=> r.cfg.rollover_sync_flag)
    else $error("Sync flag missing near a rollover.");

  AST_HIGH_ZERO: assert property (@(posedge CLK) disable iff (SRST) // RULE16
    1'b1 |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("Upper read data half not zero.");

  AST_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (SRST) // RULE16
    ($past(rd && adr == `OFS_CFG) |-> !WB_DAT_O[14])
      and ($past(rd && adr == `OFS_PAD) |-> WB_DAT_O[15:2] == 14'h0000))
    else $error("Unimplemented bits did not read as zero.");

endmodule : rtc_config_write_lock

/* verification/tb.sv */
`timescale 1ns/1ps
`include "rtc_cfg_defs.svh"

module tb;
  import rtc_cfg_pkg::*;
  logic CLK, SRST, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, TICK_IN, ALARM_PULSE, CAL_OUT;
  logic [3:0] WB_ADR_I, WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  int err_count = 0;
  int samples_checked = 0;

  rtc_config_write_lock rtc_config_write_lock_i (.CLK(CLK), .SRST(SRST), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TICK_IN(TICK_IN),
    .ALARM_PULSE(ALARM_PULSE), .CAL_OUT(CAL_OUT));

  initial begin
    CLK = 0;
    forever #4 CLK = ~CLK;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // The master waits for ack however long it takes; only the watchdog ends a hang.
  task automatic wb(input logic [3:0] a, input logic w, input logic [3:0] s, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    WB_ADR_I <= a;
    WB_WE_I <= w;
    WB_SEL_I <= s;
    WB_DAT_I <= {16'h0000, d};
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [3:0] s, input logic [15:0] e);
    wb(a, 1'b0, s, 16'h0000);
    chk(q, {16'h0000, e});
  endtask : rd

  task automatic unlock(input logic [7:0] hi);
    wb(`OFS_KEY, 1'b1, 4'h1, {8'h00, `KEY_FIRST});
    wb(`OFS_KEY, 1'b1, 4'h1, {8'h00, `KEY_SECOND});
    wb(`OFS_CFG, 1'b1, 4'h2, {hi, 8'h00});
  endtask : unlock

  task automatic pin(input logic e);
    repeat (3) @(posedge CLK);
    chk({31'h0, CAL_OUT}, {31'h0, e});
  endtask : pin

  task automatic t_regs;
    rd(`OFS_CFG, 4'hF, 16'h0000);
    rd(`OFS_PAD, 4'hF, 16'h0000);
    wb(`OFS_PAD, 1'b1, 4'h3, 16'hFFFF);
    rd(`OFS_PAD, 4'hF, 16'h0003);
    wb(`OFS_CFG, 1'b1, 4'h3, 16'hFFFF);
    rd(`OFS_CFG, 4'hF, 16'h07FF);
    wb(`OFS_CFG, 1'b1, 4'h3, 16'h0000);
    wb(`OFS_PAD, 1'b1, 4'h3, 16'h0000);
    wb(`OFS_VAL, 1'b1, 4'h3, 16'h1234);
    rd(`OFS_VAL, 4'hF, 16'h0000);
    wb(`OFS_KEY, 1'b1, 4'h1, {8'h00, `KEY_FIRST});
    rd(`OFS_CFG, 4'hF, 16'h0000);
    wb(`OFS_KEY, 1'b1, 4'h1, {8'h00, `KEY_SECOND});
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h2000);
    rd(`OFS_CFG, 4'hF, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ptr;
    unlock(8'hA3);
    rd(`OFS_CFG, 4'hF, 16'h2300);
    wb(`OFS_VAL, 1'b1, 4'h2, 16'hAB00);
    rd(`OFS_CFG, 4'hF, 16'h2200);
    wb(`OFS_VAL, 1'b1, 4'h3, 16'h0201);
    wb(`OFS_VAL, 1'b1, 4'h3, 16'h0405);
    wb(`OFS_VAL, 1'b1, 4'h3, 16'h0607);
    rd(`OFS_CFG, 4'hF, 16'h2000);
    rd(`OFS_VAL, 4'hF, 16'h0607);
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h8200);
    rd(`OFS_VAL, 4'h1, 16'h0201);
    rd(`OFS_VAL, 4'hF, 16'h0405);
    rd(`OFS_CFG, 4'hF, 16'h8000);
    wb(`OFS_VAL, 1'b1, 4'h3, 16'hFFFF);
    rd(`OFS_VAL, 4'hF, 16'h0607);
    $display("test pointer done");
  endtask : t_ptr

  task automatic t_pin;
    ALARM_PULSE <= 1'b1;
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h8400);
    pin(1'b1);
    ALARM_PULSE <= 1'b0;
    pin(1'b0);
    ALARM_PULSE <= 1'b1;
    wb(`OFS_PAD, 1'b1, 4'h1, 16'h0002);
    pin(1'b0);
    wb(`OFS_PAD, 1'b1, 4'h1, 16'h0000);
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h8000);
    pin(1'b0);
    $display("test pin done");
  endtask : t_pin

  task automatic t_half;
    wb(`OFS_PAD, 1'b1, 4'h1, 16'h0002);
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h8400);
    TICK_IN <= 1'b1;
    // Runs into the late part of the second half so the sync flag is up as well.
    repeat (32744) @(posedge CLK);
    TICK_IN <= 1'b0;
    rd(`OFS_CFG, 4'hF, 16'h9C00);
    pin(1'b1);
    unlock(8'hA4);
    wb(`OFS_VAL, 1'b1, 4'h1, 16'h0000);
    rd(`OFS_CFG, 4'hF, 16'hA400);
    pin(1'b0);
    wb(`OFS_CFG, 1'b1, 4'h2, 16'h8400);
    $display("test half second done");
  endtask : t_half

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Budget covers one long run of nearly a second plus about 45 bus cycles.
  initial begin
    repeat (60000) @(posedge CLK);
    err_count++;
    end_of_test();
  end

  initial begin
    SRST = 1'b1;
    {WB_WE_I, WB_CYC_I, WB_STB_I, TICK_IN, ALARM_PULSE} = 5'h00;
    WB_ADR_I = 4'h0;
    WB_SEL_I = 4'h0;
    WB_DAT_I = 32'h0000_0000;
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    t_regs();
    t_ptr();
    t_pin();
    t_half();
    end_of_test();
  end
endmodule : tb
